// File: verilog/adcc_pkg.sv
// Shared constants and types of the converter control block.
`default_nettype none
package adcc_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL0  = 8'h00;
    localparam logic [7:0] OFF_CTRL1  = 8'h04;
    localparam logic [7:0] OFF_RES_HI = 8'h08;
    localparam logic [7:0] OFF_RES_LO = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    // Field positions.
    localparam int FMT_BIT  = 7;
    localparam int REF_BIT  = 6;
    localparam int CHAN_LSB = 2;
    localparam int GO_BIT   = 1;
    localparam int EN_BIT   = 0;
    localparam int CS_LSB   = 4;
    localparam int DONE_BIT = 0;
    // Implemented bits; the go bit is not stored, it reflects the state.
    localparam logic [7:0] CTRL0_MASK = 8'hDD;
    localparam logic [7:0] CTRL1_MASK = 8'h70;
    // Reset values.
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] RES_RST   = 8'h00;
    // Conversion timing in conversion-clock periods.
    localparam logic [3:0] CONV_PERIODS  = 4'hB;
    localparam logic [3:0] ABORT_PERIODS = 4'h2;
    // Clock rates and the least internal oscillator period in cycles.
    localparam int CLK_SYS_HZ  = 100000000;
    localparam int FRC_MAX_HZ  = 500000;
    localparam int FRC_MIN_CYC = (CLK_SYS_HZ + FRC_MAX_HZ - 1) / FRC_MAX_HZ;
    // Divider width, enough for a divide by 64.
    localparam int DIV_W = 7;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_HOLD = 3'b100
    } adcc_state_t;

    // Division ratio of the system clock for a clock select code.
    function automatic logic [DIV_W-1:0] adcc_div(input logic [2:0] sel);
        case (sel)
            3'b000:  adcc_div = 7'h02;
            3'b100:  adcc_div = 7'h04;
            3'b001:  adcc_div = 7'h08;
            3'b101:  adcc_div = 7'h10;
            3'b010:  adcc_div = 7'h20;
            3'b110:  adcc_div = 7'h40;
            default: adcc_div = 7'h02;
        endcase
    endfunction

    // One-hot connection of an analog input.
    function automatic logic [7:0] adcc_onehot(input logic [2:0] n);
        adcc_onehot = 8'h01 << n;
    endfunction
endpackage
`default_nettype wire

// File: verilog/adcc_tick_if.sv
// Conversion clock tick link between control logic and clock generator.
`timescale 1ns/1ps
`default_nettype none
interface adcc_tick_if;
    logic       tick;
    logic       restart;
    logic [2:0] sel;
    modport gen  (input restart, input sel, output tick);
    modport user (output restart, output sel, input tick);
endinterface
`default_nettype wire

// File: verilog/adcc_clkgen.sv
// Conversion clock tick generator: system clock divider or internal RC.
`timescale 1ns/1ps
`default_nettype none
module adcc_clkgen
(
    // Clock, reset and enable.
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    // Internal RC oscillator output, asynchronous.
    input  wire logic rc_clk_in,
    // Tick link.
    adcc_tick_if.gen  tk
);
    import adcc_pkg::*;

    typedef struct packed
    {
        logic [2:0]       rc_s;
        logic             rc_lvl;
        logic [7:0]       gap;
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } adcc_gen_st_t;

    localparam logic [7:0] GAP_MIN = 8'(FRC_MIN_CYC);

    adcc_gen_st_t st;
    adcc_gen_st_t n;
    logic         rc_mode;
    logic         rc_rise;

    always_comb
    begin
        n = st;
        rc_mode = (tk.sel[1:0] == 2'b11); // RULE7
        n.rc_s = {st.rc_s[1:0], rc_clk_in};
        rc_rise = (st.rc_s[1] == st.rc_s[2]) && st.rc_s[2] && !st.rc_lvl;
        if (st.rc_s[1] == st.rc_s[2])
        begin
            n.rc_lvl = st.rc_s[2];
        end
        if (st.gap != GAP_MIN)
        begin
            n.gap = st.gap + 8'h01;
        end
        n.tick = 1'b0;
        if (tk.restart)
        begin
            n.cnt = '0;
        end
        else if (rc_mode)
        begin
            // Edges closer than the least period are dropped.
            if (rc_rise && st.gap == GAP_MIN) // RULE8
            begin
                n.tick = 1'b1;
                n.gap  = 8'h01;
            end
        end
        else if (st.cnt >= adcc_div(tk.sel) - 7'h01) // RULE7
        begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.cnt = st.cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '{rc_s: 3'h0, rc_lvl: 1'b0, gap: GAP_MIN, cnt: '0,
                    tick: 1'b0};
        end
        else if (ce)
        begin
            st <= n;
        end
    end

    assign tk.tick = st.tick;

    int unsigned gap_seen;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_seen <= 1000;
        end
        else if (ce)
        begin
            // Only internal-clock ticks restart the spacing measurement.
            gap_seen <= (n.tick && rc_mode) ? 1 : gap_seen + 1;
        end
    end

    AST_FRC_GAP: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
        ce && n.tick && rc_mode && !tk.restart |-> gap_seen >= FRC_MIN_CYC)
        else $error("internal clock ticks closer than its least period");
endmodule
`default_nettype wire

// File: verilog/adcc_top.sv
// Converter control, result registers and APB slave.
// Summary of operation
// RULE1: Format bit set packs results right-justified, cleared packs left.
// RULE2: Reference bit set picks the external reference pin, else supply.
// RULE3: Channel field n connects analog input n to the sampler.
// RULE4: Writing one to the go bit starts a conversion; hardware clears it.
// RULE5: Go bit reads one while converting, zero otherwise.
// RULE6: Enable bit powers the converter; cleared means off, no current.
// RULE7: Clock field picks system clock divided 2 to 64, or RC for x11.
// RULE8: Internal RC conversion clock runs at no more than 500 kHz.
// RULE9: Unimplemented control bits read as zero.
// RULE10: Left-justified: high holds result 9..2, low bits 7..6 hold 1..0.
// RULE11: Right-justified: high bits 1..0 hold result 9..8, rest zero.
// RULE12: Right-justified: low register holds result bits 7..0.
// RULE13: Software configures pin, clock, reference, channel, then waits.
// RULE14: Software waits a full acquisition after a channel change.
// RULE15: Software polls the go bit or waits the interrupt, then reads.
// RULE16: Software clears the completion flag; hardware never does.
// RULE17: A conversion takes eleven conversion-clock periods.
// RULE18: Completion clears go, sets done flag, loads both results.
// RULE19: Abort keeps the old result; restart waits two clock periods.
// RULE20: Completion flag is set at the end of every conversion.
// RULE21: Both result registers load in the same clock cycle.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
#(
    parameter int ADDR_W = 8
)
(
    // Clock, reset and enable.
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // APB slave.
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Analog front end.
    output logic                   converter_enable,
    output logic                   reference_sel,
    output logic      [7:0]        ain_connect,
    output logic                   sample_track,
    output logic      [9:0]        dac_trial,
    input  wire logic              cmp_in,
    input  wire logic              rc_clk_in,
    // Status.
    output logic                   conv_done_flag,
    output logic      [adcc_pkg::DIV_W-1:0] unused_div
);
    import adcc_pkg::*;

    typedef struct packed
    {
        adcc_state_t state;
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [7:0]  res_hi;
        logic [7:0]  res_lo;
        logic        done;
        logic [3:0]  per;
        logic [9:0]  dac;
        logic [9:0]  bitm;
        logic [2:0]  cmp_s;
        logic        cmp_q;
        logic [31:0] prdata;
    } adcc_top_st_t;

    localparam logic [9:0] MSB_TRIAL = 10'h200;

    adcc_top_st_t st;
    adcc_top_st_t n;
    adcc_tick_if  tk ();

    logic       acc;
    logic       wr;
    logic       hit;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [9:0] dec;
    logic       fire;
    logic       last;
    logic       sw_start;
    logic       sw_abort;
    logic       sw_off;
    logic       w_ctrl0;

    adcc_clkgen u_clkgen
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ce        (ce),
        .rc_clk_in (rc_clk_in),
        .tk        (tk)
    );

    assign tk.sel     = st.ctrl1[CS_LSB +: 3];
    assign tk.restart = sw_start || sw_abort;

    always_comb
    begin
        acc = psel && penable && ce;
        wr  = acc && pwrite;
        wd  = pwdata[7:0];
        hit = 1'b1;
        rd  = 8'h00;
        case (paddr[7:0])
            OFF_CTRL0:  rd = st.ctrl0
                             | {6'h00, st.state == ST_CONV, 1'b0}; // RULE5
            OFF_CTRL1:  rd = st.ctrl1;
            OFF_RES_HI: rd = st.res_hi;
            OFF_RES_LO: rd = st.res_lo;
            OFF_STATUS: rd = {7'h00, st.done};
            default:    hit = 1'b0;
        endcase
        if (paddr[ADDR_W-1:0] != ADDR_W'(paddr[7:0]))
        begin
            hit = 1'b0;
            rd  = 8'h00;
        end
        w_ctrl0  = wr && hit && paddr[7:0] == OFF_CTRL0;
        sw_off   = w_ctrl0 && !wd[EN_BIT];
        sw_start = w_ctrl0 && wd[EN_BIT] && wd[GO_BIT]
                   && st.state == ST_IDLE; // RULE4
        fire     = tk.tick && st.state == ST_CONV;
        last     = fire && st.per == CONV_PERIODS - 4'h1 && !sw_off; // RULE17
        sw_abort = w_ctrl0 && wd[EN_BIT] && !wd[GO_BIT]
                   && st.state == ST_CONV && !last; // RULE19
        // Keep the trial bit when the input is at or above the trial level.
        dec = st.cmp_q ? st.dac : (st.dac & ~st.bitm);
    end

    always_comb
    begin
        n = st;
        // A comparator answer needs six system clocks through the
        // synchroniser, so dividers below eight decide on stale answers.
        n.cmp_s = {st.cmp_s[1:0], cmp_in};
        if (st.cmp_s[1] == st.cmp_s[2])
        begin
            n.cmp_q = st.cmp_s[2];
        end
        if (psel && !penable)
        begin
            n.prdata = {24'h000000, rd};
        end
        if (wr && hit)
        begin
            case (paddr[7:0])
                OFF_CTRL0:  n.ctrl0 = wd & CTRL0_MASK; // RULE9
                OFF_CTRL1:  n.ctrl1 = wd & CTRL1_MASK; // RULE9
                OFF_RES_HI: n.res_hi = wd;
                OFF_RES_LO: n.res_lo = wd;
                default:    n.done = st.done && !wd[DONE_BIT]; // RULE16
            endcase
        end
        case (st.state)
            ST_IDLE:
            begin
                if (sw_start)
                begin
                    n.state = ST_CONV;
                    n.per   = 4'h0;
                    n.dac   = MSB_TRIAL;
                    n.bitm  = MSB_TRIAL;
                end
            end
            ST_CONV:
            begin
                if (sw_off)
                begin
                    n.state = ST_IDLE; // RULE6
                end
                else if (sw_abort)
                begin
                    n.state = ST_HOLD; // RULE19
                    n.per   = 4'h0;
                end
                else if (fire)
                begin
                    n.per = st.per + 4'h1;
                    // The first period holds the sample; ten decisions follow.
                    if (st.per != 4'h0)
                    begin
                        n.dac  = dec | (st.bitm >> 1);
                        n.bitm = st.bitm >> 1;
                    end
                    if (last)
                    begin
                        n.state = ST_IDLE; // RULE18
                        n.done  = 1'b1; // RULE20
                        // Both halves load together.
                        if (st.ctrl0[FMT_BIT]) // RULE1 RULE21
                        begin
                            n.res_hi = {6'h00, dec[9:8]}; // RULE11
                            n.res_lo = dec[7:0]; // RULE12
                        end
                        else
                        begin
                            n.res_hi = dec[9:2]; // RULE10
                            n.res_lo = {dec[1:0], 6'h00};
                        end
                    end
                end
            end
            ST_HOLD:
            begin
                if (sw_off)
                begin
                    n.state = ST_IDLE;
                end
                else if (tk.tick)
                begin
                    n.per = st.per + 4'h1;
                    if (st.per == ABORT_PERIODS - 4'h1) // RULE19
                    begin
                        n.state = ST_IDLE;
                    end
                end
            end
            default:
            begin
                n.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '{state: ST_IDLE, ctrl0: CTRL0_RST, ctrl1: CTRL1_RST,
                    res_hi: RES_RST, res_lo: RES_RST, done: 1'b0,
                    per: 4'h0, dac: 10'h000, bitm: 10'h000, cmp_s: 3'h0,
                    cmp_q: 1'b0, prdata: 32'h00000000};
        end
        else if (ce)
        begin
            st <= n;
        end
    end

    assign prdata           = st.prdata;
    assign pready           = psel && penable && ce;
    assign pslverr          = psel && penable && ce && !hit;
    assign converter_enable = st.ctrl0[EN_BIT]; // RULE6
    assign reference_sel    = st.ctrl0[REF_BIT]; // RULE2
    assign ain_connect      = st.ctrl0[EN_BIT]
                              ? adcc_onehot(st.ctrl0[CHAN_LSB +: 3])
                              : 8'h00; // RULE3
    assign sample_track     = st.ctrl0[EN_BIT] && st.state != ST_CONV;
    assign dac_trial        = st.dac;
    assign conv_done_flag   = st.done;
    assign unused_div       = adcc_div(st.ctrl1[CS_LSB +: 3]);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    AST_START: assert property (sw_start |=> st.state == ST_CONV) // RULE4
        else $error("start write did not begin a conversion");

    AST_GO_READ: assert property ( // RULE5
        psel && !penable && ce && paddr[7:0] == OFF_CTRL0 && hit
        |=> prdata[GO_BIT] == $past(st.state == ST_CONV))
        else $error("go bit read does not match conversion state");

    AST_EN_OFF: assert property ( // RULE6
        !st.ctrl0[EN_BIT] |-> st.state == ST_IDLE && ain_connect == 8'h00)
        else $error("converter active while disabled");

    AST_RESV: assert property ( // RULE9
        (st.ctrl0 & ~CTRL0_MASK) == 8'h00 && (st.ctrl1 & ~CTRL1_MASK) == 8'h00)
        else $error("unimplemented control bit is set");

    AST_PERIODS: assert property ( // RULE17
        st.state == ST_CONV |-> st.per < CONV_PERIODS)
        else $error("conversion ran past eleven periods");

    AST_DONE: assert property ( // RULE18
        last && ce |=> st.state == ST_IDLE && st.done)
        else $error("completion did not clear go and set the flag");

    AST_LEFT: assert property ( // RULE10
        last && ce && !st.ctrl0[FMT_BIT]
        |=> st.res_hi == $past(dec[9:2]) && st.res_lo[7:6] == $past(dec[1:0]))
        else $error("left-justified result misplaced");

    AST_RIGHT: assert property ( // RULE11
        last && ce && st.ctrl0[FMT_BIT]
        |=> st.res_hi == {6'h00, $past(dec[9:8])}
            && st.res_lo == $past(dec[7:0]))
        else $error("right-justified result misplaced");

    AST_ABORT: assert property ( // RULE19
        sw_abort |=> st.state == ST_HOLD && $stable(st.res_hi)
                     && $stable(st.res_lo))
        else $error("abort changed the result or skipped the holdoff");

    AST_CHAN: assert property ( // RULE3
        st.ctrl0[EN_BIT] |-> ain_connect == 8'h01 << st.ctrl0[CHAN_LSB +: 3])
        else $error("wrong analog input connected");

    COV_CONV: cover property (last && ce);
    COV_ABORT: cover property (sw_abort ##1 st.state == ST_HOLD);
    COV_RIGHT: cover property (last && ce && st.ctrl0[FMT_BIT]);
endmodule
`default_nettype wire

// File: test/adcc_afe_model.sv
// Behavioural analog front end: input levels, sampler, comparator, RC clock.
`timescale 1ns/1ps
`default_nettype none
module adcc_afe_model
#(
    parameter logic [79:0] VALS = 80'h0
)
(
    // Clock.
    input  wire logic       clk_sys,
    // Controls from the converter.
    input  wire logic       converter_enable,
    input  wire logic [7:0] ain_connect,
    input  wire logic       sample_track,
    input  wire logic [9:0] dac_trial,
    // Answers to the converter.
    output logic            cmp_in,
    output logic            rc_clk_in
);
    logic [9:0] held_q;

    initial
    begin
        cmp_in    = 1'b0;
        rc_clk_in = 1'b0;
        held_q    = 10'h000;
    end

    // The oscillator runs at 400 kHz, under its ceiling, only when powered.
    always #1250 rc_clk_in = converter_enable ? ~rc_clk_in : 1'b0;

    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 8; i++)
            if (sample_track && ain_connect[i])
                held_q <= VALS[i*10 +: 10];
        // Unpowered, the comparator output is meaningless, so it wanders.
        cmp_in <= converter_enable ? (held_q >= dac_trial) : ~cmp_in;
    end
endmodule
`default_nettype wire

// File: test/tb_adc_control_result_regs.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_result_regs;
    import adcc_pkg::*;
    // Inputs 0 and 1 run on the divide-by-2 and 4 settings, where the
    // comparator cannot settle, so only a full-scale input converts there.
    localparam logic [79:0] VALS = {10'h13C, 10'h2C3, 10'h3FE, 10'h001,
                                    10'h1FF, 10'h200, 10'h3FF, 10'h3FF};
    localparam logic [2:0]  CODES [8] = '{3'b000, 3'b100, 3'b001, 3'b101,
                                          3'b010, 3'b110, 3'b011, 3'b111};
    localparam int          ACQ_CYC = 20;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        converter_enable, reference_sel, sample_track;
    logic        cmp_in, rc_clk_in, conv_done_flag;
    logic [7:0]  paddr, ain_connect;
    logic [31:0] pwdata, prdata;
    logic [9:0]  dac_trial;
    logic [6:0]  unused_div;
    logic        ce;
    int          n_errors, checked, cyc;

    adcc_top u_adcc_top (.clk_sys, .rst_n, .ce, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .converter_enable,
        .reference_sel, .ain_connect, .sample_track, .dac_trial, .cmp_in,
        .rc_clk_in, .conv_done_flag, .unused_div);
    adcc_afe_model #(.VALS(VALS)) u_adcc_afe_model (.clk_sys,
        .converter_enable, .ain_connect, .sample_track, .dac_trial,
        .cmp_in, .rc_clk_in);

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) cyc <= cyc + 1;

    task close_out;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
             output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        chk(nm, exp, r);
    endtask

    task s_reset;
        logic [31:0] r;
        logic        e;
        rd(OFF_CTRL0, 32'h0, "ctrl0 reset");
        rd(OFF_CTRL1, 32'h0, "ctrl1 reset");
        rd(OFF_STATUS, 32'h0, "status reset");
        apb(1'b0, 8'h14, 8'h00, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask

    task s_bits;
        wr(OFF_CTRL0, 8'hFC);
        rd(OFF_CTRL0, 32'hDC, "ctrl0 mask");
        chk("reference pin", 32'h1, {31'h0, reference_sel});
        chk("inputs off", 32'h0, {24'h0, ain_connect});
        chk("power off", 32'h0, {31'h0, converter_enable});
        wr(OFF_CTRL1, 8'hFF);
        rd(OFF_CTRL1, 32'h70, "ctrl1 mask");
        wr(OFF_RES_HI, 8'hA5);
        rd(OFF_RES_HI, 32'hA5, "result write");
    endtask

    task s_conv(input logic [2:0] ch, input logic fmt, input logic rs,
                input logic [2:0] cs);
        logic [9:0]  v;
        logic [31:0] r;
        logic        e;
        int          t0;
        int          div;
        v   = VALS[ch*10 +: 10];
        div = (cs[1:0] == 2'b11) ? 0 : 2 << {cs[1:0], cs[2]};
        wr(OFF_STATUS, 8'h01);
        wr(OFF_CTRL1, {1'b0, cs, 4'h0});
        wr(OFF_CTRL0, {fmt, rs, 1'b0, ch, 2'b01});
        repeat (ACQ_CYC) @(posedge clk_sys);
        chk("input select", {24'h0, 8'h01 << ch}, {24'h0, ain_connect});
        chk("reference", {31'h0, rs}, {31'h0, reference_sel});
        chk("power on", 32'h1, {31'h0, converter_enable});
        if (div != 0)
            chk("divider", div, {25'h0, unused_div});
        t0 = cyc;
        wr(OFF_CTRL0, {fmt, rs, 1'b0, ch, 2'b11});
        apb(1'b0, OFF_CTRL0, 8'h00, r, e);
        chk("busy", 32'h1, {31'h0, r[1]});
        chk("sampler holds", 32'h0, {31'h0, sample_track});
        while (r[1] === 1'b1)
            apb(1'b0, OFF_CTRL0, 8'h00, r, e);
        t0 = cyc - t0;
        chk("go cleared", {24'h0, fmt, rs, 1'b0, ch, 2'b01}, r);
        if (div != 0)
            chk("time", 1, (t0 >= 11*div && t0 <= 11*div + 20));
        chk("done flag", 32'h1, {31'h0, conv_done_flag});
        rd(OFF_STATUS, 32'h1, "status done");
        rd(OFF_RES_HI, fmt ? 32'(v[9:8]) : 32'(v[9:2]), "result high");
        rd(OFF_RES_LO, fmt ? 32'(v[7:0]) : 32'({v[1:0], 6'h00}), "result low");
        wr(OFF_STATUS, 8'h01);
        chk("flag cleared", 32'h0, {31'h0, conv_done_flag});
    endtask

    task s_abort;
        logic [31:0] h;
        logic [31:0] l;
        logic        e;
        apb(1'b0, OFF_RES_HI, 8'h00, h, e);
        apb(1'b0, OFF_RES_LO, 8'h00, l, e);
        wr(OFF_CTRL1, 8'h60);
        wr(OFF_CTRL0, 8'h09);
        repeat (ACQ_CYC) @(posedge clk_sys);
        wr(OFF_CTRL0, 8'h0B);
        repeat (200) @(posedge clk_sys);
        rd(OFF_CTRL0, 32'h0B, "busy before abort");
        wr(OFF_CTRL0, 8'h09);
        wr(OFF_CTRL0, 8'h0B);
        repeat (2*64 + 20) @(posedge clk_sys);
        rd(OFF_CTRL0, 32'h09, "aborted idle");
        rd(OFF_RES_HI, h, "kept high");
        rd(OFF_RES_LO, l, "kept low");
        chk("no done", 32'h0, {31'h0, conv_done_flag});
    endtask

    // A low clock enable must hold a running conversion where it stands.
    task s_freeze;
        wr(OFF_CTRL1, 8'h10);
        wr(OFF_CTRL0, 8'h0D);
        repeat (ACQ_CYC) @(posedge clk_sys);
        wr(OFF_CTRL0, 8'h0F);
        ce <= 1'b0;
        repeat (200) @(posedge clk_sys);
        ce <= 1'b1;
        rd(OFF_CTRL0, 32'h0F, "frozen busy");
        repeat (150) @(posedge clk_sys);
        rd(OFF_CTRL0, 32'h0D, "thawed done");
        rd(OFF_STATUS, 32'h1, "thawed flag");
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        chk("watchdog", 32'h0, 32'h1);
        close_out;
    end

    initial
    begin
        {psel, penable, pwrite, rst_n} = 4'h0;
        ce       = 1'b1;
        paddr    = 8'h00;
        pwdata   = 32'h0;
        n_errors = 0;
        checked  = 0;
        cyc      = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        s_reset;
        s_bits;
        for (int i = 0; i < 8; i++)
            s_conv(i[2:0], i[0], i[1], CODES[i]);
        s_abort;
        s_freeze;
        s_conv(3'h2, 1'b0, 1'b0, 3'b001);
        wr(OFF_CTRL0, 8'h00);
        chk("power down", 32'h0, {31'h0, converter_enable});
        close_out;
    end
endmodule
`default_nettype wire
